// file: include/mmse_pkg.sv
// Package with constants and types for the min/max store and error display.
package mmse_pkg;

    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned RECALL_MS     = 2000;
    localparam int unsigned HOLD_MS       = 2000;
    localparam int unsigned LEGEND_MS     = 500;
    localparam int unsigned RECALL_CYC    = CLK_HZ / 1000 * RECALL_MS;
    localparam int unsigned HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
    localparam int unsigned LEGEND_CYC    = CLK_HZ / 1000 * LEGEND_MS;

    localparam int          VAL_W         = 16;
    localparam logic signed [15:0] DISP_MAX = 16'sd9999;
    localparam logic signed [15:0] DISP_MIN = -16'sd1999;

    localparam logic [3:0] ERR_NONE       = 4'h0;
    localparam logic [3:0] ERR_MEAS_OVER  = 4'h1;
    localparam logic [3:0] ERR_MEAS_UNDER = 4'h2;
    localparam logic [3:0] ERR_DISP_OVER  = 4'h3;
    localparam logic [3:0] ERR_DISP_UNDER = 4'h4;
    localparam logic [3:0] ERR_SYSTEM     = 4'h7;
    localparam logic [3:0] ERR_SENSOR     = 4'h9;
    localparam logic [3:0] ERR_CALC       = 4'hB;

    localparam logic [7:0] ADDR_RESET     = 8'h01;
    // The identity default is arbitrary; every unit is built with its own.
    localparam logic [31:0] UID_DEFAULT   = 32'h0000_1234;

    typedef enum logic [2:0] {
        MMSE_SHOW_LIVE,
        MMSE_SHOW_LOW_RECALL_LEGEND,
        MMSE_SHOW_HIGH_RECALL_LEGEND,
        MMSE_SHOW_CLEAR_LEGEND,
        MMSE_SHOW_MIN,
        MMSE_SHOW_MAX,
        MMSE_SHOW_ERROR
    } mmse_show_t;

    typedef struct packed {
        logic meas_over;
        logic meas_under;
        logic system_fail;
        logic sensor_fail;
        logic calc_fail;
    } mmse_diag_t;

    typedef struct packed {
        mmse_show_t         show;
        logic signed [15:0] value;
        logic [3:0]         err_code;
    } mmse_disp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [1:0] cmd;
        logic [31:0] data;
    } mmse_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } mmse_rsp_t;

    localparam logic [1:0] CMD_READ_VALUE = 2'h0;
    localparam logic [1:0] CMD_READ_UID   = 2'h1;
    localparam logic [1:0] CMD_SET_ADDR   = 2'h2;
    localparam logic [1:0] CMD_READ_ERR   = 2'h3;

endpackage

// file: src/mmse_err_class.sv
// Error classifier that turns diagnosis flags and display value into a code.
`timescale 1ns/1ps
module mmse_err_class
    import mmse_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire mmse_diag_t         diag_i,
    input  wire logic signed [15:0] disp_val_i,
    output logic [3:0]              err_code_o
);

    logic [3:0] err_next;

    // System and sensor faults win over range faults, since a range reading from a
    // broken part means nothing. All codes drop as soon as causes clear.
    always_comb begin
        err_next = ERR_NONE;
        if (diag_i.system_fail) begin
            err_next = ERR_SYSTEM;
        end else if (diag_i.sensor_fail) begin
            err_next = ERR_SENSOR;
        end else if (diag_i.meas_over) begin
            err_next = ERR_MEAS_OVER;
        end else if (diag_i.meas_under) begin
            err_next = ERR_MEAS_UNDER;
        end else if (diag_i.calc_fail) begin
            err_next = ERR_CALC;
        end else if (disp_val_i > DISP_MAX) begin
            err_next = ERR_DISP_OVER;
        end else if (disp_val_i < DISP_MIN) begin
            err_next = ERR_DISP_UNDER;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_code_o <= ERR_NONE;
        end else begin
            err_code_o <= err_next;
        end
    end

endmodule

// file: src/mmse_top.sv
// Min/max store, recall display, error display and polled serial responder.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Keep lowest and highest measured value since the last clear.
// - Short down press shows low recall legend, then minimum for 2 s.
// - Short up press shows high recall legend, then maximum for 2 s.
// - Both buttons held 2 s show clear legend, then load min/max.
// - Device answers only host requests and never sends unprompted.
// - Each device carries a unique identification number.
// - Host may assign a new bus address; device answers there.
// - Error 1 when input is above the measuring range.
// - Error 2 when input is below the measuring range.
// - Measuring range errors drop once the input is back in limits.
// - Error 3 when display value exceeds 9999.
// - Display overrange clears once value falls back to 9999.
// - Error 4 when display value is below -1999.
// - Display underrange clears once value rises back to -1999.
// - Error 7 on any self-diagnosis failure.
// - Error 9 when the sensor is broken or shorted.
// - Error 11 when a value needed for the display is faulty.
module mmse_top
    import mmse_pkg::*;
#(
    parameter int unsigned RECALL_CYCLES = RECALL_CYC,
    parameter int unsigned HOLD_CYCLES   = HOLD_CYC,
    parameter int unsigned LEGEND_CYCLES = LEGEND_CYC,
    parameter logic [31:0] UNIQUE_ID     = UID_DEFAULT
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               btn_up_i,
    input  wire logic               btn_down_i,
    input  wire logic               meas_valid_i,
    input  wire logic signed [15:0] meas_val_i,
    input  wire logic signed [15:0] disp_val_i,
    input  wire mmse_diag_t         diag_i,
    input  wire mmse_req_t          req_i,
    output mmse_rsp_t               rsp_o,
    output mmse_disp_t              disp_o,
    output logic signed [15:0]      min_o,
    output logic signed [15:0]      max_o,
    output logic [7:0]              bus_addr_o
);

    // The counter is 32 bits; the counts have to fit in it, be nonzero and keep
    // the legend shorter than the recall, so shortened simulation values stay legal.
    if (RECALL_CYCLES == 0 || HOLD_CYCLES == 0 || LEGEND_CYCLES == 0) begin
        $error("mmse_top: cycle counts must be nonzero");
    end
    if (LEGEND_CYCLES >= RECALL_CYCLES) begin
        $error("mmse_top: legend must be shorter than the recall");
    end

    //////////////////////////////////////////////////////////////////////////
    // Error classification.

    logic [3:0] err_code;

    mmse_err_class u_err (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .diag_i     (diag_i),
        .disp_val_i (disp_val_i),
        .err_code_o (err_code)
    );

    //////////////////////////////////////////////////////////////////////////
    // Button handling.

    logic        up_d_reg;
    logic        down_d_reg;
    logic        both_seen_reg;
    logic [31:0] hold_cnt_reg;
    logic        clear_req;
    logic        up_rel;
    logic        down_rel;

    // A short press acts on release, so that the start of a two-button hold
    // is not taken as a recall.
    assign up_rel   = up_d_reg && !btn_up_i && !both_seen_reg;
    assign down_rel = down_d_reg && !btn_down_i && !both_seen_reg;
    assign clear_req = btn_up_i && btn_down_i &&
                       (hold_cnt_reg == HOLD_CYCLES - 1);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_d_reg   <= 1'b0;
            down_d_reg <= 1'b0;
        end else begin
            up_d_reg   <= btn_up_i;
            down_d_reg <= btn_down_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_cnt_reg  <= 32'h0;
            both_seen_reg <= 1'b0;
        end else if (btn_up_i && btn_down_i) begin
            both_seen_reg <= 1'b1;
            if (hold_cnt_reg < HOLD_CYCLES) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
            end
        end else begin
            hold_cnt_reg <= 32'h0;
            if (!btn_up_i && !btn_down_i) begin
                both_seen_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Display sequencing.

    mmse_show_t  show_reg;
    mmse_show_t  show_next;
    logic [31:0] show_cnt_reg;
    logic [31:0] show_cnt_next;
    logic        clear_load_reg;
    logic        clear_load_next;

    always_comb begin
        show_next       = show_reg;
        show_cnt_next   = show_cnt_reg;
        clear_load_next = 1'b0;
        if (show_cnt_reg != 32'h0) begin
            show_cnt_next = show_cnt_reg - 32'h1;
        end
        case (show_reg)
            MMSE_SHOW_LOW_RECALL_LEGEND: begin
                if (show_cnt_reg == 32'h0) begin
                    show_next     = MMSE_SHOW_MIN;
                    show_cnt_next = RECALL_CYCLES;
                end
            end
            MMSE_SHOW_HIGH_RECALL_LEGEND: begin
                if (show_cnt_reg == 32'h0) begin
                    show_next     = MMSE_SHOW_MAX;
                    show_cnt_next = RECALL_CYCLES;
                end
            end
            MMSE_SHOW_CLEAR_LEGEND: begin
                if (show_cnt_reg == 32'h0) begin
                    show_next       = MMSE_SHOW_LIVE;
                    clear_load_next = 1'b1;
                end
            end
            MMSE_SHOW_MIN, MMSE_SHOW_MAX: begin
                if (show_cnt_reg == 32'h0) begin
                    show_next = MMSE_SHOW_LIVE;
                end
            end
            MMSE_SHOW_LIVE, MMSE_SHOW_ERROR: begin
                show_next = MMSE_SHOW_LIVE;
            end
            default: begin
                show_next = MMSE_SHOW_LIVE;
            end
        endcase
        // Buttons restart the sequence from any state; clear has priority.
        if (clear_req) begin
            show_next     = MMSE_SHOW_CLEAR_LEGEND;
            show_cnt_next = LEGEND_CYCLES;
        end else if (down_rel) begin
            show_next     = MMSE_SHOW_LOW_RECALL_LEGEND;
            show_cnt_next = LEGEND_CYCLES;
        end else if (up_rel) begin
            show_next     = MMSE_SHOW_HIGH_RECALL_LEGEND;
            show_cnt_next = LEGEND_CYCLES;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            show_reg       <= MMSE_SHOW_LIVE;
            show_cnt_reg   <= 32'h0;
            clear_load_reg <= 1'b0;
        end else begin
            show_reg       <= show_next;
            show_cnt_reg   <= show_cnt_next;
            clear_load_reg <= clear_load_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Minimum and maximum store.

    logic signed [15:0] min_reg;
    logic signed [15:0] max_reg;
    logic               seen_reg;

    // Until the first measurement arrives the store is empty, so the first
    // value loads both ends instead of comparing against reset zeros.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            min_reg  <= 16'sh0;
            max_reg  <= 16'sh0;
            seen_reg <= 1'b0;
        end else if (clear_load_reg) begin
            min_reg  <= disp_o.value;
            max_reg  <= disp_o.value;
            seen_reg <= 1'b1;
        end else if (meas_valid_i) begin
            seen_reg <= 1'b1;
            if (!seen_reg || meas_val_i < min_reg) begin
                min_reg <= meas_val_i;
            end
            if (!seen_reg || meas_val_i > max_reg) begin
                max_reg <= meas_val_i;
            end
        end
    end

    assign min_o = min_reg;
    assign max_o = max_reg;

    //////////////////////////////////////////////////////////////////////////
    // Display output.

    mmse_disp_t disp_next;

    always_comb begin
        disp_next.show     = show_reg;
        disp_next.err_code = ERR_NONE;
        disp_next.value    = disp_val_i;
        case (show_reg)
            MMSE_SHOW_MIN: disp_next.value = min_reg;
            MMSE_SHOW_MAX: disp_next.value = max_reg;
            default:       disp_next.value = disp_val_i;
        endcase
        // Legends and recalls are user actions and stay visible; an error
        // replaces only the live value.
        if (show_reg == MMSE_SHOW_LIVE && err_code != ERR_NONE) begin
            disp_next.show     = MMSE_SHOW_ERROR;
            disp_next.err_code = err_code;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_o <= '{show: MMSE_SHOW_LIVE, value: 16'sh0,
                        err_code: ERR_NONE};
        end else begin
            disp_o <= disp_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Polled serial responder.

    logic [7:0] addr_reg;
    mmse_rsp_t  rsp_next;
    logic       hit;

    assign hit = req_i.valid && (req_i.addr == addr_reg);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_reg <= ADDR_RESET;
        end else if (hit && req_i.cmd == CMD_SET_ADDR) begin
            addr_reg <= req_i.data[7:0];
        end
    end

    always_comb begin
        rsp_next.valid = hit;
        rsp_next.data  = 32'h0;
        case (req_i.cmd)
            CMD_READ_VALUE: rsp_next.data = {{16{disp_o.value[15]}},
                                             disp_o.value};
            CMD_READ_UID:   rsp_next.data = UNIQUE_ID;
            CMD_SET_ADDR:   rsp_next.data = {24'h0, req_i.data[7:0]};
            CMD_READ_ERR:   rsp_next.data = {28'h0, err_code};
            default:        rsp_next.data = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp_o <= '{valid: 1'b0, data: 32'h0};
        end else begin
            rsp_o <= rsp_next;
        end
    end

    assign bus_addr_o = addr_reg;

endmodule

// file: bench/mmse_top_properties.sv
// Checker for the min/max store and error display top ports.
`timescale 1ns/1ps
module mmse_top_properties
    import mmse_pkg::*;
#(
    parameter logic [31:0] UNIQUE_ID = UID_DEFAULT
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               btn_up_i,
    input  wire logic               btn_down_i,
    input  wire logic               meas_valid_i,
    input  wire logic signed [15:0] meas_val_i,
    input  wire logic signed [15:0] disp_val_i,
    input  wire mmse_diag_t         diag_i,
    input  wire mmse_req_t          req_i,
    input  wire mmse_rsp_t          rsp_o,
    input  wire mmse_disp_t         disp_o,
    input  wire logic signed [15:0] min_o,
    input  wire logic signed [15:0] max_o,
    input  wire logic [7:0]         bus_addr_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic hit;
    assign hit = req_i.valid && req_i.addr == bus_addr_o;
    //////////////////////////////////////////////////////////////////////
    reply_prompt_a: assert property (hit |=> rsp_o.valid)
        else $error("addressed request got no reply");
    reply_asked_a: assert property (rsp_o.valid |-> $past(hit))
        else $error("reply without a request");
    uid_reply_a: assert property (hit && req_i.cmd == CMD_READ_UID
        |=> rsp_o.data == UNIQUE_ID) else $error("wrong identity");
    addr_set_a: assert property (hit && req_i.cmd == CMD_SET_ADDR
        |=> bus_addr_o == $past(req_i.data[7:0]))
        else $error("bus address not taken");
    min_track_a: assert property (meas_valid_i && meas_val_i < min_o
        |=> min_o == $past(meas_val_i)) else $error("minimum missed");
    max_track_a: assert property (meas_valid_i && meas_val_i > max_o
        |=> max_o == $past(meas_val_i)) else $error("maximum missed");
    sys_err_a: assert property (diag_i.system_fail
        |-> ##2 disp_o.err_code == ERR_SYSTEM) else $error("code 7 missing");
    sensor_err_a: assert property (diag_i.sensor_fail
        && !diag_i.system_fail |-> ##2 disp_o.err_code == ERR_SENSOR)
        else $error("code 9 missing");
    disp_over_a: assert property (diag_i == '0
        && disp_val_i > DISP_MAX |-> ##2 disp_o.err_code == ERR_DISP_OVER)
        else $error("code 3 missing");
    disp_under_a: assert property (diag_i == '0
        && disp_val_i < DISP_MIN |-> ##2 disp_o.err_code == ERR_DISP_UNDER)
        else $error("code 4 missing");
    low_recall_a: assert property ($fell(btn_down_i) && !btn_up_i
        && !$past(btn_up_i) |-> ##2
        disp_o.show == MMSE_SHOW_LOW_RECALL_LEGEND)
        else $error("low recall legend missing");
    cover property (rsp_o.valid);
    cover property (disp_o.show == MMSE_SHOW_CLEAR_LEGEND);
    cover property (disp_o.show == MMSE_SHOW_MIN);
endmodule

// file: bench/mmse_panel_host.sv
// Model of the front-panel buttons and the polling serial host.
`timescale 1ns/1ps
module mmse_panel_host
    import mmse_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire mmse_rsp_t rsp_i,
    output mmse_req_t      req_o,
    output logic           btn_up_o,
    output logic           btn_down_o
);
    initial begin
        req_o = '0;
        btn_up_o = 1'b0;
        btn_down_o = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    // Both buttons are let go together so no half-released press remains.
    task automatic press(input logic up, input logic dn, input int n);
        btn_up_o = up;
        btn_down_o = dn;
        repeat (n) @(negedge clk_sys_i);
        btn_up_o = 1'b0;
        btn_down_o = 1'b0;
    endtask
    // The host only asks; idle bus lines carry the inverse, not old data.
    task automatic poll(input logic [7:0] a, input logic [1:0] c,
                        input logic [31:0] d, output mmse_rsp_t r);
        req_o = '{1'b1, a, c, d};
        @(negedge clk_sys_i);
        r = rsp_i;
        req_o = '{1'b0, ~a, ~c, ~d};
        @(negedge clk_sys_i);
    endtask
endmodule

// file: bench/minmax_store_error_display_test.sv
// Self-checking bench for the min/max store and error display.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module minmax_store_error_display_test
    import mmse_pkg::*;
;
    localparam int unsigned RC = 20;
    localparam int unsigned HC = 30;
    localparam int unsigned LC = 5;
    // Arbitrary identity value for the simulated unit.
    localparam logic [31:0] UID = 32'hA5C3_0F1E;
    logic               clk_sys_i;
    logic               rstn_i;
    logic               btn_up_i;
    logic               btn_down_i;
    logic               meas_valid_i;
    logic signed [15:0] meas_val_i;
    logic signed [15:0] disp_val_i;
    mmse_diag_t         diag_i;
    mmse_req_t          req_i;
    mmse_rsp_t          rsp_o;
    mmse_disp_t         disp_o;
    logic signed [15:0] min_o;
    logic signed [15:0] max_o;
    logic [7:0]         bus_addr_o;
    logic [7:0]         addr;
    mmse_rsp_t          r;
    int                 n_mismatch;
    int                 tests_run;
    mmse_top #(.RECALL_CYCLES(RC), .HOLD_CYCLES(HC), .LEGEND_CYCLES(LC),
        .UNIQUE_ID(UID)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .btn_up_i(btn_up_i), .btn_down_i(btn_down_i),
        .meas_valid_i(meas_valid_i), .meas_val_i(meas_val_i),
        .disp_val_i(disp_val_i), .diag_i(diag_i), .req_i(req_i),
        .rsp_o(rsp_o), .disp_o(disp_o), .min_o(min_o), .max_o(max_o),
        .bus_addr_o(bus_addr_o));
    mmse_panel_host host (.clk_sys_i(clk_sys_i), .rsp_i(rsp_o),
        .req_o(req_i), .btn_up_o(btn_up_i), .btn_down_o(btn_down_i));
    //////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_show(input mmse_show_t s, input int lim);
        int i;
        i = 0;
        while (disp_o.show !== s && i < lim) begin
            @(negedge clk_sys_i);
            i++;
        end
        tests_run++;
        if (disp_o.show !== s) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, disp_o.show, s);
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic meas(input logic signed [15:0] v);
        meas_valid_i = 1'b1;
        meas_val_i = v;
        @(negedge clk_sys_i);
        meas_valid_i = 1'b0;
        meas_val_i = ~v;
        @(negedge clk_sys_i);
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic test_serial();
        host.poll(addr, CMD_READ_UID, 32'h0, r);
        `CHK(r, {1'b1, UID})
        host.poll(8'h02, CMD_READ_UID, 32'h0, r);
        `CHK(r.valid, 1'b0)
        host.poll(addr, CMD_SET_ADDR, 32'h22, r);
        `CHK(bus_addr_o, 8'h22)
        host.poll(addr, CMD_READ_UID, 32'h0, r);
        `CHK(r.valid, 1'b0)
        addr = 8'h22;
        host.poll(addr, CMD_READ_VALUE, 32'h0, r);
        `CHK(r.valid, 1'b1)
        `CHK(r.data, 32'h0000_0064)
    endtask
    task automatic test_minmax();
        meas(16'sd5);
        meas(-16'sd7);
        meas(16'sd12);
        meas(16'sd3);
        `CHK({min_o, max_o}, {-16'sd7, 16'sd12})
    endtask
    task automatic test_recall();
        for (int k = 0; k < 2; k++) begin
            host.press(k == 1, k == 0, 3);
            wait_show(k ? MMSE_SHOW_HIGH_RECALL_LEGEND
                : MMSE_SHOW_LOW_RECALL_LEGEND, 4);
            wait_show(k ? MMSE_SHOW_MAX : MMSE_SHOW_MIN, LC + 4);
            `CHK(disp_o.value, k ? 16'sd12 : -16'sd7)
            wait_show(MMSE_SHOW_LIVE, RC + 4);
        end
    endtask
    task automatic test_clear();
        host.press(1'b1, 1'b1, HC + 3);
        `CHK(disp_o.show, MMSE_SHOW_CLEAR_LEGEND)
        wait_show(MMSE_SHOW_LIVE, LC + 8);
        repeat (3) @(negedge clk_sys_i);
        `CHK({min_o, max_o}, {16'sd100, 16'sd100})
    endtask
    // Clean entries after each range fault show that the code drops on its own.
    task automatic test_errors();
        mmse_diag_t ed [12] = '{5'h10, 5'h00, 5'h08, 5'h00, 5'h00, 5'h00,
            5'h00, 5'h00, 5'h04, 5'h02, 5'h01, 5'h1F};
        logic signed [15:0] ev [12] = '{100, 100, 100, 100, 10000, 9999,
            -2000, -1999, 100, 100, 100, 10000};
        logic [3:0] ec [12] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'h3, 4'h0, 4'h4,
            4'h0, 4'h7, 4'h9, 4'hB, 4'h7};
        for (int i = 0; i < 12; i++) begin
            diag_i = ed[i];
            disp_val_i = ev[i];
            repeat (3) @(negedge clk_sys_i);
            `CHK(disp_o.err_code, ec[i])
            `CHK(disp_o.show, ec[i] != 4'h0 ? MMSE_SHOW_ERROR
                : MMSE_SHOW_LIVE)
            host.poll(addr, CMD_READ_ERR, 32'h0, r);
            `CHK(r.data[3:0], ec[i])
        end
        diag_i = '0;
        disp_val_i = 16'sd100;
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rstn_i = 1'b0;
        meas_valid_i = 1'b0;
        meas_val_i = 16'sh0000;
        disp_val_i = 16'sd100;
        diag_i = '0;
        addr = ADDR_RESET;
        repeat (10) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        `CHK(bus_addr_o, ADDR_RESET)
        test_serial();
        test_minmax();
        test_recall();
        test_clear();
        test_errors();
        complete_run();
    end
endmodule
bind mmse_top mmse_top_properties #(.UNIQUE_ID(UNIQUE_ID)) chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .btn_up_i(btn_up_i),
    .btn_down_i(btn_down_i), .meas_valid_i(meas_valid_i),
    .meas_val_i(meas_val_i), .disp_val_i(disp_val_i), .diag_i(diag_i),
    .req_i(req_i), .rsp_o(rsp_o), .disp_o(disp_o), .min_o(min_o),
    .max_o(max_o), .bus_addr_o(bus_addr_o));
